// ---- common/led_scan_pkg.sv ----
// Constants of the LED matrix scan core
package led_scan_pkg;
    // Matrix shape
    localparam int SINKS = 12;
    localparam int LINES = 3;
    localparam int DOTS = SINKS * LINES;
    // Register offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_GLOBAL = 8'h01;
    localparam logic [7:0] ADDR_SCALE_FIRST = 8'h02;
    localparam logic [7:0] ADDR_SCALE_LAST = 8'h0D;
    localparam logic [7:0] ADDR_DUTY_FIRST = 8'h0E;
    localparam logic [7:0] ADDR_DUTY_LAST = 8'h55;
    localparam logic [7:0] ADDR_DET_FREQ = 8'h61;
    localparam logic [7:0] ADDR_OPEN_FIRST = 8'h62;
    localparam logic [7:0] ADDR_OPEN_LAST = 8'h67;
    localparam logic [7:0] ADDR_SHORT_FIRST = 8'h68;
    localparam logic [7:0] ADDR_SHORT_LAST = 8'h6D;
    localparam logic [7:0] ADDR_SPREAD = 8'h6E;
    localparam logic [7:0] ADDR_SOFT_RESET = 8'h7F;
    localparam logic [7:0] SOFT_RESET_KEY = 8'hAE;
    // Field positions
    localparam int CTRL_RES8_BIT = 6;
    localparam int CTRL_WIDTH_LSB = 4;
    localparam int DF_OPEN_BIT = 0;
    localparam int DF_SHORT_BIT = 1;
    localparam int DF_RATE_LSB = 4;
    localparam int DF_QUARTER_BIT = 7;
    localparam int SPREAD_EN_BIT = 4;
    localparam int RESULT_BITS = 6;
    // Reset value and write masks
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] CTRL_MASK = 8'h70;
    localparam logic [7:0] DET_FREQ_MASK = 8'hFF;
    localparam logic [7:0] SPREAD_MASK = 8'h10;
    // Timing, then cycles of the 40 MHz clock
    localparam int CLK_MHZ = 40;
    localparam int SCAN12_NS = 235000;
    localparam int SCAN8_NS = 15400;
    localparam int BLANK_NS = 290;
    localparam int SINK_DELAY_NS = 120;
    localparam int SPREAD_CYCLE_US = 2099;
    localparam int SCAN12_CYC = SCAN12_NS * CLK_MHZ / 1000;
    localparam int SCAN8_CYC = SCAN8_NS * CLK_MHZ / 1000;
    localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int SINK_DELAY_CYC = (SINK_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int SPREAD_CYCLE_CYC = SPREAD_CYCLE_US * CLK_MHZ;
    // Spread depth in 1/1024 units: 57/1024 is about 5.6 percent
    localparam int SPREAD_DEPTH = 57;
    localparam int SPREAD_SHIFT = 10;
    // Rate above which 12-bit mode slows
    localparam logic [2:0] RATE12_KNEE = 3'd4;
    // Widths
    localparam int LEN_W = 18;
    localparam int STEP_W = 13;
    // Scan slot phases
    typedef enum logic [1:0] {
        PH_BLANK = 2'b00,
        PH_DELAY = 2'b01,
        PH_DRIVE = 2'b10
    } phase_t;
endpackage

// ---- hw/led_matrix_scan_pwm_core.sv ----
// Scan, dimming, scaling and detect core of a 12x3 LED matrix
//
// Function
// - Writing 0xAE to reset register restores defaults
// - Power-up loads defaults, display starts dark
// - Switch lines enabled one at a time
// - Slot 235 us 12-bit, 15.4 us 8-bit
// - 0.29 us blanking, 0.12 us sink delay
// - Width 0x scans three, 10 scans two
// - Global level register sets all sink currents
// - Per-sink scaling registers at 02h to 0Dh
// - Peak current is 48 mA times both fractions
// - Quarter bit divides peak current by four
// - Duty registers 0Eh-55h, 12-bit two-byte duty
// - Resolution bit set gives one-byte 256 steps
// - Reset state is 12-bit at 4 kHz
// - Rate field sets 500 Hz to 64 kHz
// - Open trigger runs one check, results 62h-67h
// - Short trigger runs one check, results 68h-6Dh
// - Separate open and short bit per dot
// - Spread enable modulates timing 5.6 percent, 2099 us
// - Result registers read-only, top two bits zero
`timescale 1ns/1ps

module led_matrix_scan_pwm_core
    import led_scan_pkg::*;
#(
    parameter int SPREAD_CYC = SPREAD_CYCLE_CYC  // Shorten for simulation
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [SINKS-1:0] open_sense_i,
    input wire logic [SINKS-1:0] short_sense_i,
    output logic [LINES-1:0] scan_switch_lines_o,
    output logic [SINKS-1:0] current_sink_outputs_o,
    output logic [SINKS*16-1:0] sink_peak_code_o,
    output logic detect_busy_o
);

    // Spread step period, four ramps a cycle
    localparam int SS_STEP_CYC = (SPREAD_CYC / (4 * SPREAD_DEPTH) > 0) ?
                                 SPREAD_CYC / (4 * SPREAD_DEPTH) : 1;
    localparam logic [LEN_W-1:0] SCAN12_LEN = LEN_W'(SCAN12_CYC);
    localparam logic [LEN_W-1:0] SCAN8_LEN = LEN_W'(SCAN8_CYC);
    localparam logic [LEN_W-1:0] BLANK_LEN = LEN_W'(BLANK_CYC);
    localparam logic [LEN_W-1:0] DELAY_LEN = LEN_W'(SINK_DELAY_CYC);
    localparam logic [15:0] SS_STEP_LEN = 16'(SS_STEP_CYC);
    localparam logic signed [7:0] SS_MAX = 8'(SPREAD_DEPTH);

    // Register storage
    logic [7:0] ctrl_q;  // Resolution and scan width
    logic [7:0] global_current_level_q;  // Common current level
    logic [7:0] scale_q [SINKS];  // Per-sink white balance
    logic [7:0] duty_q [2*DOTS];  // Two bytes per dot
    logic [7:0] det_freq_q;  // Quarter, rate, detect triggers
    logic [7:0] spread_q;  // Spread enable
    logic [DOTS-1:0] open_res_q;  // One open bit per dot
    logic [DOTS-1:0] short_res_q;  // One short bit per dot

    // Scan engine state
    phase_t phase_q;
    logic [LEN_W-1:0] cnt_q;  // Cycles within the phase
    logic [LEN_W-1:0] len_q;  // Lit length of this slot, sink delay plus drive
    logic [1:0] line_q;  // Line being scanned
    logic [LEN_W-1:0] acc_q;  // Fractional step accumulator
    logic [STEP_W-1:0] step_q;  // Duty position within slot

    logic det_run_q;  // Detection pass under way

    logic [LINES-1:0] switch_q;
    logic [SINKS-1:0] sink_q;
    logic [7:0] rdata_q;
    logic [SINKS*16-1:0] peak_q;

    // Spread modulator
    logic [15:0] ss_cnt_q;
    logic signed [7:0] ss_dev_q;
    logic ss_up_q;

    // Decoded controls
    wire soft_rst = reg_wr_i && reg_addr_i == ADDR_SOFT_RESET &&
                    reg_wdata_i == SOFT_RESET_KEY;
    wire sync_clr = soft_rst;
    wire res8 = ctrl_q[CTRL_RES8_BIT];
    wire [1:0] width_sel = ctrl_q[CTRL_WIDTH_LSB +: 2];
    wire [2:0] rate_sel = det_freq_q[DF_RATE_LSB +: 3];
    wire quarter = det_freq_q[DF_QUARTER_BIT];
    wire open_trig = det_freq_q[DF_OPEN_BIT];
    wire short_trig = det_freq_q[DF_SHORT_BIT];
    wire spread_en = spread_q[SPREAD_EN_BIT];

    // Last scanned line: 0x three lines, 10 two, 11 one
    wire [1:0] last_line = width_sel[1] ? (width_sel[0] ? 2'd0 : 2'd1) : 2'd2;

    // Range decode for write and read
    function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // Dot duty: low byte even, high nibble odd
    function automatic logic [11:0] dot_duty(input logic [7:0] lo_b,
                                             input logic [7:0] hi_b, input logic r8);
        dot_duty = r8 ? {4'h0, lo_b} : {hi_b[3:0], lo_b};
    endfunction

    wire wr_scale = reg_wr_i && in_range(reg_addr_i, ADDR_SCALE_FIRST, ADDR_SCALE_LAST);
    wire wr_duty = reg_wr_i && in_range(reg_addr_i, ADDR_DUTY_FIRST, ADDR_DUTY_LAST);
    wire [7:0] scale_idx = reg_addr_i - ADDR_SCALE_FIRST;
    wire [7:0] duty_idx = reg_addr_i - ADDR_DUTY_FIRST;
    wire [7:0] open_idx = reg_addr_i - ADDR_OPEN_FIRST;
    wire [7:0] short_idx = reg_addr_i - ADDR_SHORT_FIRST;
    wire wr_det = reg_wr_i && reg_addr_i == ADDR_DET_FREQ;

    // Slot length
    wire [2:0] slow12 = (rate_sel > RATE12_KNEE) ? rate_sel - RATE12_KNEE : 3'd0;
    wire [LEN_W-1:0] base_len = res8 ? (SCAN8_LEN << rate_sel)
                                     : (SCAN12_LEN << slow12);

    // Spread: length scaled by 1 + dev/1024
    wire signed [LEN_W+8:0] ss_prod = $signed({1'b0, base_len}) * ss_dev_q;
    wire signed [LEN_W+8:0] ss_adj = ss_prod >>> SPREAD_SHIFT;
    wire [LEN_W-1:0] slot_len = spread_en ? base_len + ss_adj[LEN_W-1:0]
                                          : base_len;
    wire [LEN_W-1:0] drive_len = len_q - DELAY_LEN;

    // Phase ends
    wire blank_end = phase_q == PH_BLANK && cnt_q == BLANK_LEN - 1'b1;
    wire delay_end = phase_q == PH_DELAY && cnt_q == DELAY_LEN - 1'b1;
    wire drive_end = phase_q == PH_DRIVE && cnt_q == drive_len - 1'b1;
    wire frame_start = blank_end && line_q == 2'd0;
    wire frame_end = drive_end && line_q == last_line;
    wire run_start = frame_start && (open_trig || short_trig) && !det_run_q;
    wire run_done = frame_end && det_run_q;

    // Duty steps spread over the drive length
    wire [LEN_W-1:0] step_res = res8 ? LEN_W'(256) : LEN_W'(4096);
    wire [LEN_W-1:0] acc_sum = acc_q + step_res;
    wire acc_wrap = acc_sum >= drive_len;

    // Register file
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= REG_RESET;
            global_current_level_q <= REG_RESET;
            det_freq_q <= REG_RESET;
            spread_q <= REG_RESET;
            for (int i = 0; i < SINKS; i++) scale_q[i] <= REG_RESET;
            for (int i = 0; i < 2*DOTS; i++) duty_q[i] <= REG_RESET;
        end else if (sync_clr) begin
            ctrl_q <= REG_RESET;
            global_current_level_q <= REG_RESET;
            det_freq_q <= REG_RESET;
            spread_q <= REG_RESET;
            for (int i = 0; i < SINKS; i++) scale_q[i] <= REG_RESET;
            for (int i = 0; i < 2*DOTS; i++) duty_q[i] <= REG_RESET;
        end else begin

            // Control, level, spread
            if (reg_wr_i && reg_addr_i == ADDR_CTRL) ctrl_q <= reg_wdata_i & CTRL_MASK;
            if (reg_wr_i && reg_addr_i == ADDR_GLOBAL) begin
                global_current_level_q <= reg_wdata_i;
            end
            if (reg_wr_i && reg_addr_i == ADDR_SPREAD) spread_q <= reg_wdata_i & SPREAD_MASK;

            // Scale and duty bytes taken any time
            if (wr_scale) scale_q[scale_idx[3:0]] <= reg_wdata_i;
            if (wr_duty) duty_q[duty_idx[6:0]] <= reg_wdata_i;

            // Triggers self-clear; a host write wins
            if (wr_det) begin
                det_freq_q <= reg_wdata_i & DET_FREQ_MASK;
            end else if (run_done) begin
                det_freq_q[DF_OPEN_BIT] <= 1'b0;
                det_freq_q[DF_SHORT_BIT] <= 1'b0;
            end
        end
    end

    // Detection: one pass per trigger
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            det_run_q <= 1'b0;
            open_res_q <= '0;
            short_res_q <= '0;
        end else if (sync_clr) begin
            det_run_q <= 1'b0;
            open_res_q <= '0;
            short_res_q <= '0;
        end else begin
            if (run_start) begin
                det_run_q <= 1'b1;

                // Lines outside the scan width report clean
                if (open_trig) open_res_q <= '0;
                if (short_trig) short_res_q <= '0;
            end else if (run_done) begin
                det_run_q <= 1'b0;
            end

            // Sample on the last drive cycle
            if (drive_end && det_run_q) begin
                if (open_trig) begin
                    open_res_q[line_q*SINKS +: SINKS] <= open_sense_i;
                end
                if (short_trig) begin
                    short_res_q[line_q*SINKS +: SINKS] <= short_sense_i;
                end
            end
        end
    end

    // Spread triangle between -depth and +depth
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ss_cnt_q <= '0;
            ss_dev_q <= '0;
            ss_up_q <= 1'b1;
        end else if (sync_clr || !spread_en) begin
            ss_cnt_q <= '0;
            ss_dev_q <= '0;
            ss_up_q <= 1'b1;
        end else if (ss_cnt_q == SS_STEP_LEN - 1'b1) begin
            ss_cnt_q <= '0;

            // Turn at the extremes
            if (ss_up_q && ss_dev_q == SS_MAX) begin
                ss_up_q <= 1'b0;
                ss_dev_q <= ss_dev_q - 8'sd1;
            end else if (!ss_up_q && ss_dev_q == -SS_MAX) begin
                ss_up_q <= 1'b1;
                ss_dev_q <= ss_dev_q + 8'sd1;
            end else begin
                ss_dev_q <= ss_up_q ? ss_dev_q + 8'sd1 : ss_dev_q - 8'sd1;
            end
        end else begin
            ss_cnt_q <= ss_cnt_q + 16'd1;
        end
    end

    // Slot sequencer: blank, sink delay, drive
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_q <= PH_BLANK;
            cnt_q <= '0;
            len_q <= SCAN12_LEN;
            line_q <= 2'd0;
        end else if (sync_clr) begin
            phase_q <= PH_BLANK;
            cnt_q <= '0;
            len_q <= SCAN12_LEN;
            line_q <= 2'd0;
        end else begin
            case (phase_q)
                PH_BLANK: begin
                    // Length fixed per slot, mode changes wait
                    cnt_q <= blank_end ? '0 : cnt_q + 1'b1;
                    if (blank_end) begin
                        phase_q <= PH_DELAY;
                        len_q <= slot_len;
                    end
                end
                PH_DELAY: begin
                    cnt_q <= delay_end ? '0 : cnt_q + 1'b1;
                    if (delay_end) phase_q <= PH_DRIVE;
                end
                PH_DRIVE: begin
                    cnt_q <= drive_end ? '0 : cnt_q + 1'b1;
                    if (drive_end) begin
                        phase_q <= PH_BLANK;

                        // Wrap also when the width shrinks mid-frame
                        line_q <= (line_q >= last_line) ? 2'd0 : line_q + 2'd1;
                    end
                end
                default: begin
                    phase_q <= PH_BLANK;
                    cnt_q <= '0;
                end
            endcase
        end
    end

    // Duty position: restarts at each drive phase
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_q <= '0;
            step_q <= '0;
        end else if (sync_clr || phase_q != PH_DRIVE) begin
            acc_q <= '0;
            step_q <= '0;
        end else if (acc_wrap) begin
            acc_q <= acc_sum - drive_len;
            step_q <= step_q + 1'b1;
        end else begin
            acc_q <= acc_sum;
        end
    end

    // Per-sink compare and peak current code
    logic [SINKS-1:0] sink_d;
    genvar s;
    generate
        for (s = 0; s < SINKS; s++) begin : g_sink
            wire [6:0] lo_i = 7'((line_q * SINKS + s) * 2);
            wire [11:0] duty = dot_duty(duty_q[lo_i], duty_q[lo_i + 7'd1], res8);
            assign sink_d[s] = (phase_q == PH_DRIVE) && ({1'b0, duty} > step_q);

            // Code c gives 48 mA * c / 65536
            wire [15:0] full = global_current_level_q * scale_q[s];
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    peak_q[s*16 +: 16] <= '0;
                end else begin
                    peak_q[s*16 +: 16] <= quarter ? (full >> 2) : full;
                end
            end
        end
    endgenerate

    // Pins: one line at a time, dark while blanking
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            switch_q <= '0;
            sink_q <= '0;
        end else begin
            switch_q <= (phase_q != PH_BLANK && !sync_clr) ?
                        LINES'(1 << line_q) : '0;
            sink_q <= sync_clr ? '0 : sink_d;
        end
    end

    // Read data registered after the strobe
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (reg_addr_i == ADDR_CTRL) rd_mux = ctrl_q;
        else if (reg_addr_i == ADDR_GLOBAL) rd_mux = global_current_level_q;
        else if (in_range(reg_addr_i, ADDR_SCALE_FIRST, ADDR_SCALE_LAST)) begin
            rd_mux = scale_q[scale_idx[3:0]];
        end else if (in_range(reg_addr_i, ADDR_DUTY_FIRST, ADDR_DUTY_LAST)) begin
            rd_mux = duty_q[duty_idx[6:0]];
        end else if (reg_addr_i == ADDR_DET_FREQ) rd_mux = det_freq_q;
        else if (in_range(reg_addr_i, ADDR_OPEN_FIRST, ADDR_OPEN_LAST)) begin
            rd_mux = {2'b00, open_res_q[open_idx[2:0]*RESULT_BITS +: RESULT_BITS]};
        end else if (in_range(reg_addr_i, ADDR_SHORT_FIRST, ADDR_SHORT_LAST)) begin
            rd_mux = {2'b00, short_res_q[short_idx[2:0]*RESULT_BITS +: RESULT_BITS]};
        end else if (reg_addr_i == ADDR_SPREAD) rd_mux = spread_q;
        else rd_mux = 8'h00;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) rdata_q <= 8'h00;
        else if (reg_rd_i) rdata_q <= rd_mux;
    end

    assign reg_rdata_o = rdata_q;
    assign scan_switch_lines_o = switch_q;
    assign current_sink_outputs_o = sink_q;
    assign sink_peak_code_o = peak_q;
    assign detect_busy_o = det_run_q;

endmodule // led_matrix_scan_pwm_core

// ---- test/led_host_model.sv ----
// Host model writing the core registers on the falling edge
`timescale 1ns/1ps
module led_host_model
    import led_scan_pkg::*;
(
    input wire logic clk_i,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i
);
    // Idle bus at time zero
    initial begin
        {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = '0;
    end
    // One-edge write; released lines show inverse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        {reg_addr_o, reg_wdata_o, reg_wr_o} = {a, d, 1'b1};
        @(negedge clk_i);
        {reg_addr_o, reg_wdata_o, reg_wr_o} = {~a, ~d, 1'b0};
    endtask
    // One-edge read; data taken a cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        {reg_addr_o, reg_rd_o} = {a, 1'b1};
        @(negedge clk_i);
        {reg_addr_o, reg_rd_o} = {~a, 1'b0};
        d = reg_rdata_i;
    endtask
    // Detect pass: presets, then trigger
    task automatic detect(input int k);
        wr(ADDR_GLOBAL, 8'h0F);
        wr(8'h60, 8'h00);
        wr(ADDR_DET_FREQ, 8'(1 << k));
    endtask
endmodule // led_host_model

// ---- test/led_matrix_scan_pwm_core_properties.sv ----
// Port-level checks bound to the LED scan core
`timescale 1ns/1ps
module led_scan_checker
    import led_scan_pkg::*;
#(
    parameter int SPREAD_CYC = SPREAD_CYCLE_CYC  // Same as the core
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [LINES-1:0] scan_switch_lines_o,
    input wire logic [SINKS-1:0] current_sink_outputs_o,
    input wire logic [SINKS*16-1:0] sink_peak_code_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire soft_w = reg_wr_i && reg_addr_i == ADDR_SOFT_RESET && reg_wdata_i == SOFT_RESET_KEY;
    wire cfg_w = reg_wr_i && reg_addr_i inside {ADDR_CTRL, ADDR_DET_FREQ, ADDR_SPREAD, 8'h7F};
    wire lit = scan_switch_lines_o != '0;
    logic [7:0] regs_q [128];  // Shadow of every written register
    logic [17:0] on_q;  // Cycles the current line has been lit
    logic [1:0] dirty_q;  // Slots whose timing a config write may blur
    logic [1:0] last_q;  // Last line lit
    logic [SINKS*16-1:0] code_exp;
    wire [7:0] glob = regs_q[1];
    wire [7:0] df = regs_q[ADDR_DET_FREQ[6:0]];
    wire [2:0] rate = df[DF_RATE_LSB+:3];
    wire [1:0] width = regs_q[0][CTRL_WIDTH_LSB+:2];
    wire [1:0] idx = scan_switch_lines_o[2] ? 2'd2 : {1'b0, scan_switch_lines_o[1]};
    wire [1:0] nxt = width == 2'b11 ? 2'd0 : width == 2'b10 ? {1'b0, last_q == 2'd0}
        : (last_q == 2'd2 ? 2'd0 : last_q + 2'd1);
    wire [17:0] len_exp = regs_q[0][CTRL_RES8_BIT] ? 18'd616 << rate
        : 18'd9400 << (rate > 3'd4 ? rate - 3'd4 : 3'd0);
    // Shadow registers, cleared with the core
    always_ff @(posedge clk_i or posedge rst_i) begin
        for (int a = 0; a < 128; a++) begin
            if (rst_i || soft_w) regs_q[a] <= 8'h00;
            else if (reg_wr_i && reg_addr_i == 8'(a)) regs_q[a] <= reg_wdata_i;
        end
    end
    // Lit-time counter; config taint lasts two slots
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            on_q <= '0;
            dirty_q <= '0;
            last_q <= 2'd2;
        end else begin
            on_q <= lit ? on_q + 18'd1 : 18'd0;
            if (lit && on_q == '0) last_q <= idx;
            if (cfg_w) dirty_q <= 2'd2;
            else if (!lit && on_q != '0 && dirty_q != '0) dirty_q <= dirty_q - 2'd1;
        end
    end
    // Expected peak codes, quarter mode truncates
    always_comb begin
        for (int s = 0; s < SINKS; s++)
            code_exp[16*s+:16] = (16'(glob) * 16'(regs_q[2+s])) >> (df[DF_QUARTER_BIT] ? 2 : 0);
    end
    sequence s_on; !lit ##1 lit; endsequence
    sequence s_off; lit ##1 !lit; endsequence
    AST_ONE_LINE: assert property ($onehot0(scan_switch_lines_o))
        else $error("more than one switch line lit");
    AST_DARK_IN_BLANK: assert property (!lit |-> current_sink_outputs_o == '0)
        else $error("sink on while no line lit");
    AST_SINK_DELAY: assert property (s_on |-> (current_sink_outputs_o == '0)[*5])
        else $error("sink on inside turn-on delay");
    AST_BLANK_LEN: assert property (s_off |-> (!lit)[*8] ##1 (!lit)[*4])
        else $error("blanking shorter than twelve cycles");
    AST_SLOT_LEN: assert property (!lit && on_q != '0 && dirty_q == '0
        && !regs_q[ADDR_SPREAD[6:0]][SPREAD_EN_BIT] |-> on_q == len_exp)
        else $error("scan slot length wrong");
    AST_LINE_ORDER: assert property (lit && on_q == '0 && dirty_q == '0
        |-> scan_switch_lines_o == 3'b001 << nxt) else $error("switch line order wrong");
    AST_PEAK_CODE: assert property (sink_peak_code_o == $past(code_exp))
        else $error("peak code does not follow level and scale");
    AST_RESULT_TOP: assert property (reg_rd_i && reg_addr_i inside {[8'h62:8'h6D]}
        |=> reg_rdata_o[7:6] == 2'b00) else $error("result top bits not zero");
    AST_GLOBAL_RD: assert property (reg_rd_i && reg_addr_i == ADDR_GLOBAL
        |=> reg_rdata_o == $past(glob)) else $error("global level read back wrong");
endmodule // led_scan_checker
bind led_matrix_scan_pwm_core led_scan_checker #(.SPREAD_CYC(SPREAD_CYC)) u_props (.*);

// ---- test/tb_led_matrix_scan_pwm_core.sv ----
// Self-checking bench for the LED matrix scan and dimming core
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_led_matrix_scan_pwm_core;
    import led_scan_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr, wdata, rdata, got, g;
    logic [7:0] sc [SINKS];  // Scale values written
    logic wr, rd, busy;
    logic [SINKS-1:0] open_s = '0, short_s = '0;
    logic [SINKS-1:0] sinks, pat;
    logic [LINES-1:0] sw, ln;
    logic [SINKS*16-1:0] peak;
    int mismatches = 0;
    int checks_done = 0;
    int seed = 32'h7f1096c2;
    int on, len, lo, hi, d;
    always #12.5 clk_i = ~clk_i;
    led_host_model u_host (.clk_i(clk_i), .reg_addr_o(addr), .reg_wdata_o(wdata),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdata));
    // Short spread cycle for simulation
    led_matrix_scan_pwm_core #(.SPREAD_CYC(912)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .open_sense_i(open_s), .short_sense_i(short_s),
        .scan_switch_lines_o(sw), .current_sink_outputs_o(sinks),
        .sink_peak_code_o(peak), .detect_busy_o(busy));
    function automatic int exp_on(int duty, int full, int n);
        return (duty * (n - 5) + full - 1) / full;
    endfunction
    function automatic logic near(int a, int b);
        return (a - b) inside {[-2:2]};
    endfunction
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        u_host.rd(a, got);
        `CHK(got, e)
    endtask
    // Measures one whole slot on sink 0
    task automatic slot;
        int n;
        n = 0;
        while (sw != '0 && n < 20000) begin @(negedge clk_i); n++; end
        while (sw == '0 && n < 20000) begin @(negedge clk_i); n++; end
        {ln, on, len} = {sw, 32'd0, 32'd0};
        while (sw != '0 && n < 20000) begin on += sinks[0]; len++; @(negedge clk_i); n++; end
        if (n >= 20000) begin mismatches++; wrap_up(); end
    endtask
    initial begin
        repeat (10) @(negedge clk_i);
        `CHK({sw, sinks, busy, peak}, '0)
        rst_i = 1'b0;
        slot();
        `CHK({ln, len, on}, {3'b001, 32'd9400, 32'd0})
        for (int a = 0; a <= 8'h6E; a++) rdchk(8'(a), 8'h00);
        // Random level and scales, sink 0 full scale
        g = 8'($random(seed));
        u_host.wr(ADDR_GLOBAL, g);
        for (int s = 0; s < SINKS; s++) begin
            sc[s] = (s == 0) ? 8'hFF : 8'($random(seed));
            u_host.wr(ADDR_SCALE_FIRST + 8'(s), sc[s]);
        end
        for (int q = 0; q < 2; q++) begin
            u_host.wr(ADDR_DET_FREQ, 8'(q << DF_QUARTER_BIT));
            repeat (2) @(negedge clk_i);
            for (int s = 0; s < SINKS; s++)
                `CHK(peak[16*s+:16], (16'(g) * 16'(sc[s])) >> (2 * q))
        end
        rdchk(ADDR_GLOBAL, g);
        rdchk(ADDR_SCALE_LAST, sc[11]);
        u_host.wr(8'h64, 8'hFF);
        rdchk(8'h64, 8'h00);
        u_host.wr(8'h70, 8'h5A);
        rdchk(8'h70, 8'h00);
        // Two-byte duty on sink 0 of every line
        d = $random(seed) & 32'hFFF;
        for (int l = 0; l < LINES; l++) begin
            u_host.wr(ADDR_DUTY_FIRST + 8'(24 * l), d[7:0]);
            u_host.wr(ADDR_DUTY_FIRST + 8'(24 * l + 1), {4'h0, d[11:8]});
        end
        slot();
        `CHK(near(on, exp_on(d, 4096, 9400)), 1'b1)
        // One-byte duty rewritten every slot, three, two, one line
        for (int w = 0; w < 3; w++) begin
            u_host.wr(ADDR_CTRL, w ? 8'h50 + 8'(w << 4) : 8'h40);
            slot();
            for (int k = 0; k < 4; k++) begin
                d = (k == 0) ? 0 : (k == 1) ? 255 : $random(seed) & 32'hFF;
                lo = w == 2 ? 1 : w ? (ln == 3'b001 ? 2 : 1) : {ln[1:0], ln[2]};
                u_host.wr(ADDR_DUTY_FIRST + 8'(24 * (lo >> 1)), d[7:0]);
                slot();
                `CHK({ln, len}, {3'(lo), 32'd616})
                `CHK(near(on, exp_on(d, 256, 616)), 1'b1)
            end
        end
        for (int r = 1; r < 4; r++) begin
            u_host.wr(ADDR_DET_FREQ, 8'(r << DF_RATE_LSB));
            slot();
            slot();
            `CHK(len, 616 << r)
        end
        // Open then short pass, random patterns
        u_host.wr(ADDR_CTRL, 8'h40);
        for (int k = 0; k < 2; k++) begin
            open_s = SINKS'($random(seed));
            short_s = SINKS'($random(seed));
            pat = k ? short_s : open_s;
            u_host.detect(k);
            d = 0;
            while (busy !== 1'b1 && d < 5000) begin @(negedge clk_i); d++; end
            while (busy !== 1'b0 && d < 5000) begin @(negedge clk_i); d++; end
            if (d >= 5000) begin mismatches++; wrap_up(); end
            for (int r = 0; r < 6; r++)
                rdchk(8'h62 + 8'(6 * k + r), {2'b00, pat[(r % 2) * 6+:6]});
            rdchk(ADDR_DET_FREQ, 8'h00);
        end
        u_host.wr(ADDR_SPREAD, 8'hFF);
        rdchk(ADDR_SPREAD, 8'h10);
        {lo, hi} = {32'd9999, 32'd0};
        repeat (12) begin
            slot();
            {lo, hi} = {(len < lo) ? len : lo, (len > hi) ? len : hi};
        end
        `CHK({lo < hi, lo >= 581, hi <= 650}, 3'b111)
        u_host.wr(ADDR_SOFT_RESET, 8'h55);
        rdchk(ADDR_GLOBAL, 8'h0F);
        u_host.wr(ADDR_SOFT_RESET, SOFT_RESET_KEY);
        foreach (sc[i]) rdchk(8'(i), 8'h00);
        rdchk(ADDR_SPREAD, 8'h00);
        slot();
        `CHK(len, 9400)
        wrap_up();
    end
endmodule // tb_led_matrix_scan_pwm_core
